// ==== rtl/cbsx_cond.sv ====
/*
 * cbsx_cond: branch condition evaluator, purely combinational.
 * assumes: flags come straight from the condition code register.
 */
`timescale 1ns/1ps
module cbsx_cond (
  input  wire logic [3:0] i_cc,    // condition field
  input  wire logic [7:0] i_ccr,   // condition code register
  output logic            o_take   // branch taken
);
  import cbsx_pkg::*;
  logic c, v, z, n, base;          // unpacked flags and even-code result
  // odd codes are the inverse sense of the even code below them
  always_comb begin
    c = i_ccr[CBSX_C];
    v = i_ccr[CBSX_V];
    z = i_ccr[CBSX_Z];
    n = i_ccr[CBSX_N];
    unique case (i_cc[3:1])
      3'h0: base = 1'b1;                 // always / never
      3'h1: base = ~(c | z);             // high / low or same
      3'h2: base = ~c;                   // carry clear / set
      3'h3: base = ~z;                   // not equal / equal
      3'h4: base = ~v;                   // overflow clear / set
      3'h5: base = ~n;                   // plus / minus
      3'h6: base = ~(n ^ v);             // ge / lt
      3'h7: base = ~(z | (n ^ v));       // gt / le
    endcase
    o_take = base ^ i_cc[0];
  end
endmodule

// ==== rtl/cbsx_exec.sv ====
/*
 * cbsx_exec: executes carry bit operations, branches, system control
 * instructions and block moves for a cpu built of 2-byte units.
 * assumes: a memory port with read/write strobes and read data
 * valid while the strobe stands; one core clock.
 * general registers are 16-bit halves: index k = r(k) low word, k+8 the
 * extended half; byte forms use the low byte of a half.
 */
`timescale 1ns/1ps
module cbsx_exec (
  input  wire logic        i_core_clk,  // core clock 10 MHz
  input  wire logic        i_rst,       // sync reset, active high
  output logic [23:0]      o_mem_addr,  // memory byte address
  output logic             o_mem_rd,    // read strobe
  output logic             o_mem_wr,    // write strobe
  output logic             o_mem_word,  // 1 word access, 0 byte
  output logic [15:0]      o_mem_wdata, // write data
  input  wire logic [15:0] i_mem_rdata, // read data, while strobe stands
  output logic [23:0]      o_pc,        // program counter
  output logic [7:0]       o_ccr,       // condition code register
  output logic [7:0]       o_exr,       // extended control register
  output logic             o_sleep,     // power-down state
  output logic             o_in_trap,   // inside exception handler
  input  wire logic        i_wake       // wake from power-down
);
  import cbsx_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [3:0] {
    CBSX_FETCH, CBSX_DECODE, CBSX_EXT, CBSX_EXEC, CBSX_MWAIT,
    CBSX_POPH, CBSX_POPL, CBSX_MOVRD, CBSX_MOVWR, CBSX_SLEEPING
  } cbsx_state_t;

  cbsx_state_t state_reg, state_next;   // sequencer
  logic [23:0] pc_reg, pc_next;         // program counter
  logic [23:0] sp_reg, sp_next;         // stack pointer
  logic [15:0] ir_reg, ir_next;         // instruction word
  logic [15:0] ext_reg, ext_next;       // extension word
  logic [7:0]  ccr_reg, ccr_next;       // condition codes
  logic [7:0]  exr_reg, exr_next;       // extended control
  logic [23:0] tmp_reg, tmp_next;       // popped address high part
  logic [2:0]  push_reg, push_next;     // pending push words
  logic        trap_reg, trap_next;     // handler active
  logic [23:0] madr_reg, madr_next;     // memory address
  logic        mrd_reg, mrd_next;       // read strobe
  logic        mwr_reg, mwr_next;       // write strobe
  logic        mwd_reg, mwd_next;       // word access
  logic [15:0] mwdat_reg, mwdat_next;   // write data
  logic [15:0] cnt_reg, cnt_next;       // block move count
  logic [23:0] src_reg, src_next;       // block move source
  logic [23:0] dst_reg, dst_next;       // block move destination
  logic        mvw_reg, mvw_next;       // word-count form

  // register file port
  logic        rf_we;
  logic [3:0]  rf_waddr, rf_raddr;
  logic [15:0] rf_wdata, rf_rdata;
  logic        take;                    // branch condition result

  // decoded fields
  logic [3:0]  op, sub, rd;
  logic [2:0]  bitno;
  logic        inv, sel_exr, opbit, cval;
  logic [7:0]  ctl, ctl_res;
  logic [23:0] ret_pc;

  cbsx_regs #(.N(16)) u_regs (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_we       (rf_we),
    .i_waddr    (rf_waddr),
    .i_wdata    (rf_wdata),
    .i_raddr    (rf_raddr),
    .o_rdata    (rf_rdata)
  );

  cbsx_cond u_cond (
    .i_cc   (ir_reg[CBSX_SUB_HI:CBSX_SUB_LO]),
    .i_ccr  (ccr_reg),
    .o_take (take)
  );

  ////////////////////////////////////////////////////////////////////////
  // field decode
  always_comb begin
    op      = ir_reg[CBSX_OP_HI:CBSX_OP_LO];
    sub     = ir_reg[CBSX_SUB_HI:CBSX_SUB_LO];
    rd      = ir_reg[CBSX_RD_HI:CBSX_RD_LO];
    bitno   = ir_reg[CBSX_BIT_HI:CBSX_BIT_LO];
    inv     = ir_reg[CBSX_INV_BIT];
    sel_exr = ir_reg[CBSX_EXR_SEL];
    opbit   = rf_rdata[bitno];
    cval    = ccr_reg[CBSX_C];
    ctl     = sel_exr ? exr_reg : ccr_reg;
    ret_pc  = pc_reg;
    unique case (op)
      CBSX_OP_CAND: ctl_res = ctl & ir_reg[7:0];
      CBSX_OP_COR:  ctl_res = ctl | ir_reg[7:0];
      default:      ctl_res = ctl ^ ir_reg[7:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    ir_next    = ir_reg;
    ext_next   = ext_reg;
    ccr_next   = ccr_reg;
    exr_next   = exr_reg;
    tmp_next   = tmp_reg;
    push_next  = push_reg;
    trap_next  = trap_reg;
    madr_next  = madr_reg;
    mrd_next   = 1'b0;
    mwr_next   = 1'b0;
    mwd_next   = 1'b1;
    mwdat_next = mwdat_reg;
    cnt_next   = cnt_reg;
    src_next   = src_reg;
    dst_next   = dst_reg;
    mvw_next   = mvw_reg;
    rf_we      = 1'b0;
    rf_waddr   = rd;
    rf_wdata   = rf_rdata;
    rf_raddr   = rd;
    unique case (state_reg)
      CBSX_FETCH: begin
        // every fetch is one 2-byte unit
        madr_next  = pc_reg;
        mrd_next   = 1'b1;
        pc_next    = pc_reg + CBSX_INST_STEP;
        state_next = CBSX_DECODE;
      end
      CBSX_DECODE: begin
        ir_next = i_mem_rdata;
        // jumps, absolute calls and memory control moves carry one extension
        if (i_mem_rdata[15:12] == CBSX_OP_JMP ||
            i_mem_rdata[15:12] == CBSX_OP_CALL ||
            (i_mem_rdata[15:12] == CBSX_OP_SYS &&
             (i_mem_rdata[11:8] == CBSX_S_LDCM ||
              i_mem_rdata[11:8] == CBSX_S_STCM))) begin
          madr_next  = pc_reg;
          mrd_next   = 1'b1;
          pc_next    = pc_reg + CBSX_INST_STEP;
          state_next = CBSX_EXT;
        end else begin
          state_next = CBSX_EXEC;
        end
      end
      CBSX_EXT: begin
        ext_next   = i_mem_rdata;
        state_next = CBSX_EXEC;
      end
      CBSX_EXEC: begin
        state_next = CBSX_FETCH;
        unique case (op)
          CBSX_OP_BIT: begin
            if (sub == CBSX_B_XOR) begin
              ccr_next[CBSX_C] = cval ^ (opbit ^ inv);
            end else if (sub == CBSX_B_LD) begin
              ccr_next[CBSX_C] = opbit ^ inv;
            end else if (sub == CBSX_B_ST) begin
              rf_we           = 1'b1;
              rf_wdata[bitno] = cval ^ inv;
            end
          end
          CBSX_OP_BCC: begin
            if (take) begin
              pc_next = pc_reg + {{16{ir_reg[7]}}, ir_reg[7:0]};
            end
          end
          CBSX_OP_JMP: begin
            pc_next = {8'h00, ext_reg};
          end
          CBSX_OP_CALL, CBSX_OP_RCAL: begin
            // push return low word and branch in one cycle, then push high byte of the new pc
            sp_next    = sp_reg - CBSX_INST_STEP;
            madr_next  = sp_reg - CBSX_INST_STEP;
            mwr_next   = 1'b1;
            mwdat_next = ret_pc[15:0];
            push_next  = 3'h1;
            pc_next    = (op == CBSX_OP_JMP || op == CBSX_OP_CALL) ?
                         {8'h00, ext_reg} :
                         pc_reg + {{16{ir_reg[7]}}, ir_reg[7:0]};
            state_next = CBSX_MWAIT;
          end
          CBSX_OP_CAND, CBSX_OP_COR, CBSX_OP_CXOR: begin
            if (sel_exr) exr_next = ctl_res;
            else         ccr_next = ctl_res;
          end
          CBSX_OP_SYS: begin
            unique case (sub)
              CBSX_S_NOP: ;
              CBSX_S_SLEEP: state_next = CBSX_SLEEPING;
              CBSX_S_TRAP: begin
                // save pc low word, then ccr with I already set and high byte of the new pc; fetch through vector
                sp_next    = sp_reg - CBSX_INST_STEP;
                madr_next  = sp_reg - CBSX_INST_STEP;
                mwr_next   = 1'b1;
                mwdat_next = ret_pc[15:0];
                push_next  = 3'h2;
                trap_next  = 1'b1;
                ccr_next[CBSX_I] = 1'b1;
                pc_next    = CBSX_TRAP_VEC +
                             ({22'h0, ir_reg[5:4]} << CBSX_VEC_SHIFT);
                state_next = CBSX_MWAIT;
              end
              CBSX_S_RTE, CBSX_S_RTS: begin
                madr_next  = sp_reg;
                mrd_next   = 1'b1;
                sp_next    = sp_reg + CBSX_INST_STEP;
                state_next = CBSX_POPL;
              end
              CBSX_S_LDCR, CBSX_S_LDCI: begin
                if (sel_exr) exr_next = (sub == CBSX_S_LDCI) ?
                                        ir_reg[7:0] : rf_rdata[7:0];
                else ccr_next = (sub == CBSX_S_LDCI) ?
                                ir_reg[7:0] : rf_rdata[7:0];
              end
              CBSX_S_LDCM: begin
                madr_next  = {8'h00, ext_reg};
                mrd_next   = 1'b1;
                state_next = CBSX_POPH;
              end
              CBSX_S_STCR: begin
                rf_we    = 1'b1;
                rf_wdata = {rf_rdata[15:8], ctl};
              end
              CBSX_S_STCM: begin
                madr_next  = {8'h00, ext_reg};
                mwr_next   = 1'b1;
                mwdat_next = {ctl, 8'h00};
                state_next = CBSX_MWAIT;
              end
              CBSX_S_MOVB, CBSX_S_MOVW: begin
                mvw_next   = (sub == CBSX_S_MOVW);
                state_next = CBSX_MOVRD;
                push_next  = 3'h4;                   // load operands
              end
              default: ;
            endcase
          end
          default: ;
        endcase
      end
      CBSX_MWAIT: begin
        // second push word for calls and traps
        if (push_reg == 3'h1 || push_reg == 3'h2) begin
          sp_next    = sp_reg - CBSX_INST_STEP;
          madr_next  = sp_reg - CBSX_INST_STEP;
          mwr_next   = 1'b1;
          mwdat_next = (push_reg == 3'h2) ?
                       {ccr_reg, ret_pc[23:16]} : {8'h00, ret_pc[23:16]};
          push_next  = 3'h0;
        end else begin
          state_next = CBSX_FETCH;
        end
      end
      CBSX_POPL: begin
        // high word {flags, pc high byte} stands now; ask for the low word
        tmp_next   = {i_mem_rdata[7:0], 16'h0000};
        if (sub == CBSX_S_RTE) ccr_next = i_mem_rdata[15:8];
        madr_next  = sp_reg;
        mrd_next   = 1'b1;
        sp_next    = sp_reg + CBSX_INST_STEP;
        state_next = CBSX_POPH;
      end
      CBSX_POPH: begin
        if (op == CBSX_OP_SYS && sub == CBSX_S_LDCM) begin
          if (sel_exr) exr_next = i_mem_rdata[15:8];
          else         ccr_next = i_mem_rdata[15:8];
          state_next = CBSX_FETCH;
        end else begin
          pc_next = {tmp_reg[23:16], i_mem_rdata};
          if (sub == CBSX_S_RTE) trap_next = 1'b0;
          state_next = CBSX_FETCH;
        end
      end
      CBSX_MOVRD: begin
        // operand load: r4 count, r5 source, r6 destination
        if (push_reg != 3'h0) begin
          push_next = push_reg - 3'h1;
          unique case (push_reg)
            3'h4: rf_raddr = 4'h4;
            3'h3: rf_raddr = 4'h5;
            3'h2: rf_raddr = 4'hd;
            default: rf_raddr = 4'h6;
          endcase
          if (push_reg == 3'h4) begin
            cnt_next = mvw_reg ? rf_rdata : {8'h00, rf_rdata[7:0]};
          end else if (push_reg == 3'h3) begin
            src_next = {src_reg[23:16], rf_rdata};
          end else if (push_reg == 3'h2) begin
            src_next = {rf_rdata[7:0], src_reg[15:0]};
          end else begin
            dst_next = {8'h00, rf_rdata};
          end
        end else if (cnt_reg == 16'h0000) begin
          state_next = CBSX_FETCH;
        end else begin
          madr_next  = src_reg;
          mrd_next   = 1'b1;
          mwd_next   = 1'b0;
          state_next = CBSX_MOVWR;
        end
      end
      CBSX_MOVWR: begin
        madr_next  = dst_reg;
        mwr_next   = 1'b1;
        mwd_next   = 1'b0;
        mwdat_next = {8'h00, i_mem_rdata[7:0]};
        src_next   = src_reg + CBSX_BYTE_STEP;
        dst_next   = dst_reg + CBSX_BYTE_STEP;
        cnt_next   = cnt_reg - 16'h0001;
        rf_we      = 1'b1;
        rf_waddr   = 4'h4;                           // count written back
        rf_raddr   = 4'h4;
        rf_wdata   = mvw_reg ? cnt_reg - 16'h0001 :
                     {rf_rdata[15:8], cnt_reg[7:0] - 8'h01};
        state_next = CBSX_MOVRD;
      end
      CBSX_SLEEPING: begin
        if (i_wake) state_next = CBSX_FETCH;
      end
      default: state_next = CBSX_FETCH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_core_clk) begin
    // synchronous reset folded into each register's input mux
    state_reg <= i_rst ? CBSX_FETCH   : state_next;
    pc_reg    <= i_rst ? CBSX_PC_RST  : pc_next;
    sp_reg    <= i_rst ? CBSX_SP_RST  : sp_next;
    ir_reg    <= i_rst ? 16'h0000     : ir_next;
    ext_reg   <= i_rst ? 16'h0000     : ext_next;
    ccr_reg   <= i_rst ? CBSX_CCR_RST : ccr_next;
    exr_reg   <= i_rst ? CBSX_EXR_RST : exr_next;
    tmp_reg   <= i_rst ? 24'h000000   : tmp_next;
    push_reg  <= i_rst ? 3'h0         : push_next;
    trap_reg  <= i_rst ? 1'b0         : trap_next;
    madr_reg  <= i_rst ? 24'h000000   : madr_next;
    mrd_reg   <= i_rst ? 1'b0         : mrd_next;
    mwr_reg   <= i_rst ? 1'b0         : mwr_next;
    mwd_reg   <= i_rst ? 1'b1         : mwd_next;
    mwdat_reg <= i_rst ? 16'h0000     : mwdat_next;
    cnt_reg   <= i_rst ? 16'h0000     : cnt_next;
    src_reg   <= i_rst ? 24'h000000   : src_next;
    dst_reg   <= i_rst ? 24'h000000   : dst_next;
    mvw_reg   <= i_rst ? 1'b0         : mvw_next;
  end

  // outputs straight from flip-flops, o_sleep decoded from state_reg
  assign o_mem_addr  = madr_reg;
  assign o_mem_rd    = mrd_reg;
  assign o_mem_wr    = mwr_reg;
  assign o_mem_word  = mwd_reg;
  assign o_mem_wdata = mwdat_reg;
  assign o_pc        = pc_reg;
  assign o_ccr       = ccr_reg;
  assign o_exr       = exr_reg;
  assign o_sleep     = (state_reg == CBSX_SLEEPING);
  assign o_in_trap   = trap_reg;
endmodule

// ==== rtl/cbsx_regs.sv ====
/*
 * cbsx_regs: sixteen-by-16-bit general register halves with one write port
 * and one unregistered read port shared by r4, the r5 pair, r6 and operand reg.
 * assumes: writes are one cycle, read-after-write shows the old value.
 */
`timescale 1ns/1ps
module cbsx_regs #(
  parameter int N = 16                   // 16-bit register halves
) (
  input  wire logic        i_core_clk,  // core clock
  input  wire logic        i_rst,       // sync reset
  input  wire logic        i_we,        // write enable
  input  wire logic [3:0]  i_waddr,     // write index
  input  wire logic [15:0] i_wdata,     // write data
  input  wire logic [3:0]  i_raddr,     // read index
  output logic      [15:0] o_rdata      // read data
);
  logic [15:0] mem_reg [N];             // storage
  logic [15:0] mem_next [N];            // next storage
  // single write port
  always_comb begin
    for (int k = 0; k < N; k++) begin
      mem_next[k] = mem_reg[k];
    end
    if (i_we) begin
      mem_next[i_waddr] = i_wdata;
    end
  end
  always_ff @(posedge i_core_clk) begin
    for (int k = 0; k < N; k++) begin
      mem_reg[k] <= i_rst ? 16'h0000 : mem_next[k];
    end
  end
  assign o_rdata = mem_reg[i_raddr];
endmodule

// ==== shared/cbsx_pkg.sv ====
/*
 * cbsx_pkg: constants, encodings and types for the bit-operation, branch,
 * system-control and block-move execution block.
 * assumes: one core clock, synchronous active-high reset, a simple
 * word-wide memory port on the far side.
 */
// Summary of operation
// - bit xor to carry: C ^= bit
// - inverted xor: C ^= ~bit, 3-bit number
// - bit load: C = bit, operand unchanged
// - inverted load: C = ~bit
// - bit store: bit = C, others kept
// - inverted store: bit = ~C
// - branch taken per sixteen condition codes
// - trap starts exception handling
// - trap 2-bit field picks vector
// - exception return resumes interrupted program
// - sleep enters power-down state
// - load control: word read, upper byte
// - store control: word write, upper byte
// - and/or/xor control register with immediate
// - no-op advances pc by two only
// - block move copies, steps pointers, counts down
// - count r4 low/word, src r5, dst r6
// - next instruction after final byte moved
// - instructions are 2-byte units
// - op field in first four bits, maybe two
// - register fields 3 or 4 bits
// - extension word gives imm, address, displacement; here address only, imm and disp in low byte
package cbsx_pkg;
  localparam int CBSX_AW = 24;                   // address width
  localparam logic [23:0] CBSX_PC_RST   = 24'h000100; // reset pc
  localparam logic [23:0] CBSX_SP_RST   = 24'h00fff0; // reset stack ptr
  localparam logic [23:0] CBSX_TRAP_VEC = 24'h000020; // trap vector base
  localparam logic [23:0] CBSX_INST_STEP = 24'h000002; // 2-byte unit
  localparam logic [23:0] CBSX_BYTE_STEP = 24'h000001; // byte step
  localparam logic [1:0]  CBSX_VEC_SHIFT = 2'h2;      // 4-byte vectors
  localparam logic [7:0]  CBSX_CCR_RST  = 8'h80;      // interrupt mask set
  localparam logic [7:0]  CBSX_EXR_RST  = 8'h07;      // trace off, mask 7
  // ccr bit positions
  localparam int CBSX_C = 0;
  localparam int CBSX_V = 1;
  localparam int CBSX_Z = 2;
  localparam int CBSX_N = 3;
  localparam int CBSX_I = 7;
  // instruction field positions
  localparam int CBSX_OP_HI   = 15;              // first op field 15:12
  localparam int CBSX_OP_LO   = 12;
  localparam int CBSX_SUB_HI  = 11;              // second op field 11:8
  localparam int CBSX_SUB_LO  = 8;
  localparam int CBSX_BIT_HI  = 6;               // 3-bit bit number
  localparam int CBSX_BIT_LO  = 4;
  localparam int CBSX_INV_BIT = 7;               // inverted form select
  localparam int CBSX_RD_HI   = 3;               // 4-bit register field
  localparam int CBSX_RD_LO   = 0;
  localparam int CBSX_EXR_SEL = 3;               // 1 selects extended reg
  // first op field codes
  localparam logic [3:0] CBSX_OP_SYS  = 4'h0;    // system group
  localparam logic [3:0] CBSX_OP_BCC  = 4'h4;    // cond branch, cc 11:8
  localparam logic [3:0] CBSX_OP_BIT  = 4'h7;    // bit group
  localparam logic [3:0] CBSX_OP_CAND = 4'h6;    // and imm to control
  localparam logic [3:0] CBSX_OP_COR  = 4'h5;    // or imm to control
  localparam logic [3:0] CBSX_OP_CXOR = 4'h3;    // xor imm to control
  localparam logic [3:0] CBSX_OP_JMP  = 4'h8;    // jump, ext target
  localparam logic [3:0] CBSX_OP_CALL = 4'h9;    // call, ext target
  localparam logic [3:0] CBSX_OP_RCAL = 4'ha;    // relative call, disp
  // second op field codes, bit group
  localparam logic [3:0] CBSX_B_XOR = 4'h5;
  localparam logic [3:0] CBSX_B_LD  = 4'h7;
  localparam logic [3:0] CBSX_B_ST  = 4'h8;
  // second op field codes, system group
  localparam logic [3:0] CBSX_S_NOP   = 4'h0;
  localparam logic [3:0] CBSX_S_SLEEP = 4'h1;
  localparam logic [3:0] CBSX_S_TRAP  = 4'h2;
  localparam logic [3:0] CBSX_S_RTE   = 4'h3;
  localparam logic [3:0] CBSX_S_RTS   = 4'h4;
  localparam logic [3:0] CBSX_S_LDCR  = 4'h5;    // from register
  localparam logic [3:0] CBSX_S_LDCM  = 4'h6;    // from memory, ext addr
  localparam logic [3:0] CBSX_S_STCR  = 4'h7;    // to register
  localparam logic [3:0] CBSX_S_STCM  = 4'h8;    // to memory, ext addr
  localparam logic [3:0] CBSX_S_MOVB  = 4'h9;    // block move, byte count
  localparam logic [3:0] CBSX_S_MOVW  = 4'ha;    // block move, word count
  localparam logic [3:0] CBSX_S_LDCI  = 4'hb;    // immediate in low byte
  typedef enum logic [1:0] {
    CBSX_MEM_IDLE,
    CBSX_MEM_RD,
    CBSX_MEM_WR
  } cbsx_mem_t;
endpackage

// ==== tb/cbsx_exec_checker.sv ====
/* checker: port rules of the exec block
   assumes: bound to cbsx_exec, one clock */
`timescale 1ns/1ps
module cbsx_exec_checker (
  input wire logic        i_core_clk, i_rst, i_wake, // clock, reset, wake
  input wire logic        o_mem_rd, o_mem_word,      // read, width
  input wire logic        o_sleep, o_in_trap,        // states
  input wire logic [23:0] o_mem_addr, o_pc,          // address, pc
  input wire logic [15:0] i_mem_rdata,               // read data
  input wire logic [7:0]  o_ccr                      // flags
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_rd_single: assert property (
    o_mem_rd ##1 o_mem_rd |=> !o_mem_rd) else $error("read strobe held");
  chk_word_even: assert property (
    o_mem_rd && o_mem_word |-> !o_mem_addr[0]) else $error("odd word");
  chk_wake_exit: assert property (o_sleep && i_wake |=> !o_sleep)
    else $error("sleep kept after wake");
  chk_sleep_quiet: assert property (
    o_sleep && !i_wake |=> $stable(o_pc) && !o_mem_rd)
    else $error("activity while asleep");
  chk_nop_step: assert property (
    o_mem_rd && i_mem_rdata == 16'h0000 |=> ##2 o_mem_rd &&
    o_mem_addr == $past(o_mem_addr, 3) + 24'h000002 &&
    o_ccr == $past(o_ccr, 3))
    else $error("no-op step wrong");
  chk_ldc_imm: assert property (
    o_mem_rd && i_mem_rdata[15:8] == 8'h0b && !i_mem_rdata[3]
    |=> ##1 o_ccr == $past(i_mem_rdata[7:0], 2))
    else $error("flag load wrong");
  chk_bra_always: assert property (
    o_mem_rd && i_mem_rdata[15:8] == 8'h40 |=> ##2 o_mem_rd &&
    o_mem_addr == $past(o_mem_addr, 3) + 24'h000002 +
    {{16{$past(i_mem_rdata[7], 3)}}, $past(i_mem_rdata[7:0], 3)})
    else $error("branch target wrong");
  chk_trap_enter: assert property (
    o_mem_rd && i_mem_rdata[15:8] == 8'h02 |=> ##1 o_in_trap)
    else $error("trap not entered");
endmodule
bind cbsx_exec cbsx_exec_checker chk (.i_core_clk, .i_rst, .i_wake,
  .o_mem_rd, .o_mem_word, .o_sleep, .o_in_trap, .o_mem_addr, .o_pc,
  .i_mem_rdata, .o_ccr);

// ==== tb/cbsx_exec_tb.sv ====
/* cbsx_exec_tb: runs a generated program through the exec block
   assumes: cbsx_mem answers every read at once */
`timescale 1ns/1ps
module cbsx_exec_tb;
  import cbsx_pkg::*;
  logic clk = 0, rst = 1, wake = 0, rd, wr, word, slp, trap, i;
  logic [23:0] addr, pc, at;
  logic [15:0] wdata, rdata, r0;
  logic [7:0] condition_code_register, extended_control_register, fl;
  logic [31:0] q[$], wq[$]; // notes: flags/next fetch; expected writes
  int errors = 0, checks = 0, s;
  logic [2:0] b;
  cbsx_exec dut (.i_core_clk(clk), .i_rst(rst), .o_mem_addr(addr),
    .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_word(word), .o_mem_wdata(wdata),
    .i_mem_rdata(rdata), .o_pc(pc), .o_ccr(condition_code_register), .o_exr(extended_control_register),
    .o_sleep(slp), .o_in_trap(trap), .i_wake(wake));
  cbsx_mem mem (.i_core_clk(clk), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata));
  initial forever #50 clk = ~clk;
  task automatic cmp(input string n, input logic [31:0] e, g);
    checks++;
    if (e !== g) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic put(input logic [15:0] w, input logic [23:0] nx);
    mem.m[at[11:1]] = w;
    at = nx;
    q.push_back({fl, nx});
  endtask
  function automatic logic taken(input logic [3:0] c, input logic [7:0] f);
    logic [7:0] t;
    t = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0],
      f[0] | f[2], 1'b0};
    return t[c[3:1]] ^ !c[0];
  endfunction
  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // each word fetch and each write takes the oldest note of its kind;
  // byte reads of a block move are not fetches
  always @(posedge clk) if (!rst && q.size() > 0) begin
    if (rd && word) cmp("fetch", q[0][23:0], addr);
    if (rd && word) cmp("flags", q.pop_front() >> 24, condition_code_register);
    if (wr) cmp("write", wq.size() ? wq.pop_front() : 32'hffffffff,
      {addr[14:0], word, wdata});
  end
  initial begin
    #(5000 * 100);
    errors++;
    results();
  end
  initial begin
    void'($urandom(30));
    for (int k = 0; k < 2048; k++) mem.m[k] = 16'h1111;
    at = CBSX_PC_RST;
    fl = CBSX_CCR_RST;
    r0 = 0;
    q.push_back({fl, at});
    fl = 0;
    put(16'h0b00, at + 2);
    put(16'h0000, at + 2);
    repeat (12) begin
      s = $urandom % 3;
      b = $urandom;
      i = $urandom;
      if (s == 0) fl[0] = fl[0] ^ r0[b] ^ i;
      else if (s == 1) fl[0] = r0[b] ^ i;
      else r0[b] = fl[0] ^ i;
      put({4'h7, s == 0 ? CBSX_B_XOR : s == 1 ? CBSX_B_LD : CBSX_B_ST,
        i, b, 4'h0}, at + 2);
    end
    for (int c = 0; c < 16; c++) begin
      fl = $urandom & 8'h07; // N stays clear: bit 3 of ldc imm selects exr
      put({8'h0b, fl}, at + 2);
      put({4'h4, c[3:0], 8'h02}, at + (taken(c[3:0], fl) ? 4 : 2));
    end
    fl = 8'h01;
    put({8'h0b, fl}, at + 2);
    put({4'h7, CBSX_B_ST, 4'h1, 4'h4}, at + 2);
    wq.push_back(32'h00000011); // byte 0 to 0: fill pattern low byte
    wq.push_back(32'h00020011); // byte 1 to 1
    put({CBSX_OP_SYS, CBSX_S_MOVB, 8'h00}, at + 2);
    put({CBSX_OP_SYS, CBSX_S_MOVW, 8'h00}, at + 2);
    put({CBSX_OP_SYS, CBSX_S_SLEEP, 8'h00}, at + 2);
    mem.m[at[11:1]] = 16'h0220;
    repeat (16) @(posedge clk);
    rst <= 0;
    for (int n = 0; n < 3000 && !slp; n++) @(posedge clk);
    cmp("sleep", 1, slp);
    repeat (4) @(posedge clk);
    wake <= 1;
    @(posedge clk);
    wake <= 0;
    for (int n = 0; n < 100 && !trap; n++) @(posedge clk);
    cmp("trap", 1, trap);
    cmp("notes", 0, q.size());
    cmp("writes", 0, wq.size());
    results();
  end
endmodule

// ==== tb/cbsx_mem.sv ====
/* cbsx_mem: word memory behind the exec block
   assumes: answers while the read strobe stands */
`timescale 1ns/1ps
module cbsx_mem (
  input  wire logic        i_core_clk, // clock
  input  wire logic [23:0] i_addr,     // byte address
  input  wire logic        i_rd,       // read strobe
  input  wire logic        i_wr,       // write strobe
  input  wire logic [15:0] i_wdata,    // write data
  output logic      [15:0] o_rdata  // read data
);
  logic [15:0] m [0:2047]; // 2-byte units, wraps at 4 kbyte
  // data stand with the strobe; idle shows the inverse so stale
  // values never look valid
  assign o_rdata = i_rd ? m[i_addr[11:1]] : ~m[i_addr[11:1]];
  always @(posedge i_core_clk) begin
    if (i_wr) m[i_addr[11:1]] <= i_wdata; // word writes only
  end
endmodule
